// ---- design/bpmc_pkg.sv ----
// shared constants and types for the bidirectional port mode control block
// assumes a single 20 MHz clock; all strap pins arrive as digitised pin voltage codes
`default_nettype none

package bpmc_pkg;

    // clock
    localparam int CLK_PERIOD_NS = 50;

    // pin voltage code: full scale equals the supply
    localparam int CODE_W = 8;
    localparam int THR_LR_TENTHS = 2;
    localparam int THR_RF_TENTHS = 5;
    localparam int THR_FH_TENTHS = 8;
    localparam int FLOAT_NUM = 2;
    localparam int FLOAT_DEN = 3;

    // timing: least times, rounded up to whole cycles
    localparam int DEBOUNCE_TIME_NS = 10000;
    localparam int DEBOUNCE_CYCLES = (DEBOUNCE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DRAIN_TIME_NS = 500;
    localparam int DRAIN_CYCLES = (DRAIN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CDR_RESET_TIME_NS = 1000;
    localparam int CDR_RESET_CYCLES = (CDR_RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int POR_READY_TIME_MS = 50;
    localparam int POR_READY_CYCLES = (POR_READY_TIME_MS * 1000000 + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;

    // four-level strap states
    typedef enum logic [1:0] {
        LVL_L = 2'h0,
        LVL_R = 2'h1,
        LVL_F = 2'h2,
        LVL_H = 2'h3
    } bpmc_level_type;

    // port mode sequencer states, one-hot
    typedef enum logic [4:0] {
        ST_STRAP = 5'h01,
        ST_EQ = 5'h02,
        ST_DRV = 5'h04,
        ST_QUIET = 5'h08,
        ST_CDR_RST = 5'h10
    } bpmc_state_type;

endpackage

`default_nettype wire

// ---- design/bpmc_level_pin.sv ----
// four-level strap pin conditioner: decode, two-flop resync, debounce
// assumes pin_code is a sampled pin voltage with full scale equal to the supply
`timescale 1ns/10ps
`default_nettype none

module bpmc_level_pin #(
    parameter int CODE_W = bpmc_pkg::CODE_W,
    parameter int DEBOUNCE_CYCLES = bpmc_pkg::DEBOUNCE_CYCLES
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [CODE_W-1:0] pin_code,
    input wire logic pin_open,
    output var bpmc_pkg::bpmc_level_type level,
    output logic level_valid,
    output logic level_high
);
    localparam int SW = CODE_W + 4;
    localparam int FULL = (1 << CODE_W) - 1;
    localparam int CNT_W = $clog2(DEBOUNCE_CYCLES + 1);
    localparam logic [SW-1:0] T_LR = SW'(FULL * bpmc_pkg::THR_LR_TENTHS);
    localparam logic [SW-1:0] T_RF = SW'(FULL * bpmc_pkg::THR_RF_TENTHS);
    localparam logic [SW-1:0] T_FH = SW'(FULL * bpmc_pkg::THR_FH_TENTHS);
    localparam logic [CODE_W-1:0] FLOAT_CODE =
        CODE_W'((FULL * bpmc_pkg::FLOAT_NUM) / bpmc_pkg::FLOAT_DEN);
    localparam logic [SW-1:0] TEN = SW'(10);

    wire logic [CODE_W-1:0] eff_code;
    wire logic [SW-1:0] scaled;
    bpmc_pkg::bpmc_level_type raw_level;
    bpmc_pkg::bpmc_level_type sync1;
    bpmc_pkg::bpmc_level_type sync2;
    bpmc_pkg::bpmc_level_type candidate;
    logic [CNT_W-1:0] cnt;
    wire logic settled;

    // an open pin sits at the internal bias point
    assign eff_code = pin_open ? FLOAT_CODE : pin_code; // RULE13
    assign scaled = SW'(eff_code) * TEN;
    // thresholds at tenths of full scale; equality falls to the upper state
    assign raw_level = (scaled < T_LR) ? bpmc_pkg::LVL_L :
                       (scaled < T_RF) ? bpmc_pkg::LVL_R :
                       (scaled < T_FH) ? bpmc_pkg::LVL_F : bpmc_pkg::LVL_H; // RULE12
    assign settled = (cnt == CNT_W'(DEBOUNCE_CYCLES - 1));

    // two-flop resync; sync1 feeds only sync2
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sync1 <= bpmc_pkg::LVL_L;
            sync2 <= bpmc_pkg::LVL_L;
        end else begin
            sync1 <= raw_level;
            sync2 <= sync1;
        end
    end

    // debounce: level only moves after the candidate held for the full count
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            candidate <= bpmc_pkg::LVL_L;
            cnt <= '0;
            level <= bpmc_pkg::LVL_L;
            level_valid <= 1'b0;
            level_high <= 1'b0;
        end else if (sync2 != candidate) begin
            candidate <= sync2;
            cnt <= '0;
        end else if (settled) begin
            level <= candidate; // RULE15
            level_high <= candidate[1];
            level_valid <= 1'b1;
        end else begin
            cnt <= cnt + CNT_W'(1);
        end
    end

    a_open_pin_float: assert property (@(posedge clk) disable iff (reset) // RULE13
        pin_open |-> raw_level == bpmc_pkg::LVL_F)
        else $error("open strap pin did not decode as float");
    a_level_extremes: assert property (@(posedge clk) disable iff (reset) // RULE12
        (!pin_open && (pin_code == '0)) |-> raw_level == bpmc_pkg::LVL_L)
        else $error("zero pin voltage did not decode as low");
    a_level_top: assert property (@(posedge clk) disable iff (reset) // RULE12
        (!pin_open && (pin_code == '1)) |-> raw_level == bpmc_pkg::LVL_H)
        else $error("full pin voltage did not decode as high");
    a_level_debounced: assert property (@(posedge clk) disable iff (reset) // RULE15
        $changed(level) |-> $past(settled) && ($past(candidate) == level))
        else $error("strap level changed without a full debounce count");

endmodule

`default_nettype wire

// ---- design/bpmc_port_control.sv ----
// bidirectional coax port mode control: direction, routing and relock sequencing
// assumes strap pins as voltage codes, serial data as clk-rate bit samples,
// and an external analog reclocker driven by the recovery reset and source select
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// RULE1: direction select low gives equalizer mode: coax input, equalizer on, driver off.
// RULE2: direction select high gives driver mode: coax driven from host input.
// RULE3: coax equalizer and coax driver are never both enabled.
// RULE4: the direction level alone picks the mode and powers down the other way.
// RULE5: equalizer mode reclocks coax input onto the host differential output.
// RULE6: equalizer mode offers a reclocked loop-through on the secondary driver.
// RULE7: driver mode offers the reclocked host input on the secondary driver too.
// RULE8: driver mode can loop reclocked host input back on the host output.
// RULE9: the system straps the direction select before power is applied.
// RULE10: after power-up the direction may change either way at any time.
// RULE11: every direction change resets the clock recovery loop before relocking.
// RULE12: four-level pins decode at 0.2, 0.5 and 0.8 of supply.
// RULE13: an open four-level pin biases to two thirds supply and reads float.
// RULE14: the controller waits the ready time before management bus access.
// RULE15: selects are resynced and debounced; old drivers stop before new start.
module bpmc_port_control #(
    parameter int CODE_W = bpmc_pkg::CODE_W,
    parameter int DEBOUNCE_CYCLES = bpmc_pkg::DEBOUNCE_CYCLES,
    parameter int DRAIN_CYCLES = bpmc_pkg::DRAIN_CYCLES,
    parameter int CDR_RESET_CYCLES = bpmc_pkg::CDR_RESET_CYCLES,
    parameter int POR_READY_CYCLES = bpmc_pkg::POR_READY_CYCLES
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [CODE_W-1:0] direction_select_code,
    input wire logic direction_select_open,
    input wire logic [CODE_W-1:0] host_output_route_select_code,
    input wire logic host_output_route_select_open,
    input wire logic [CODE_W-1:0] secondary_driver_select_code,
    input wire logic secondary_driver_select_open,
    input wire logic line_coax_port_in,
    output logic line_coax_port_out,
    output logic line_coax_port_oe,
    input wire logic host_diff_input,
    output logic host_diff_output,
    output logic host_diff_output_enable,
    output logic secondary_coax_driver,
    output logic secondary_coax_driver_enable,
    output logic line_equalizer_enable,
    output logic host_equalizer_enable,
    output logic clock_recovery_reset,
    output logic clock_recovery_source_host,
    output logic equalizer_mode,
    output logic driver_mode,
    output logic mgmt_ready
);
    localparam int WAIT_MAX = (DRAIN_CYCLES > CDR_RESET_CYCLES) ? DRAIN_CYCLES : CDR_RESET_CYCLES;
    localparam int WAIT_W = $clog2(WAIT_MAX + 1);
    localparam int POR_W = $clog2(POR_READY_CYCLES + 1);
    localparam int A_RELOCK_MAX = 200;

    bpmc_pkg::bpmc_state_type state;
    bpmc_pkg::bpmc_state_type next_state;
    logic target_host;
    logic next_target_host;
    logic [WAIT_W-1:0] wait_cnt;
    logic [POR_W-1:0] por_cnt;
    logic reclocked;

    wire logic dir_valid;
    wire logic dir_high;
    wire logic route_valid;
    wire logic route_high;
    wire logic sec_valid;
    wire logic sec_high;

    // strap pins: L/R read as low, F/H read as high
    bpmc_level_pin #(.CODE_W(CODE_W), .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)) u_dir_pin (
        .clk(clk),
        .reset(reset),
        .pin_code(direction_select_code),
        .pin_open(direction_select_open),
        .level(),
        .level_valid(dir_valid),
        .level_high(dir_high)
    );
    bpmc_level_pin #(.CODE_W(CODE_W), .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)) u_route_pin (
        .clk(clk),
        .reset(reset),
        .pin_code(host_output_route_select_code),
        .pin_open(host_output_route_select_open),
        .level(),
        .level_valid(route_valid),
        .level_high(route_high)
    );
    bpmc_level_pin #(.CODE_W(CODE_W), .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)) u_sec_pin (
        .clk(clk),
        .reset(reset),
        .pin_code(secondary_driver_select_code),
        .pin_open(secondary_driver_select_open),
        .level(),
        .level_valid(sec_valid),
        .level_high(sec_high)
    );

    // state decodes and timer completion
    wire logic in_eq = (state == bpmc_pkg::ST_EQ);
    wire logic in_drv = (state == bpmc_pkg::ST_DRV);
    wire logic drain_done = (wait_cnt == WAIT_W'(DRAIN_CYCLES - 1));
    wire logic cdr_done = (wait_cnt == WAIT_W'(CDR_RESET_CYCLES - 1));
    wire logic dir_moved = dir_valid && (dir_high != target_host); // RULE10

    // mode sequencer: a direction change drains drivers, resets recovery, then relocks
    always_comb begin
        next_state = state;
        next_target_host = target_host;
        case (state)
            bpmc_pkg::ST_STRAP: begin
                if (dir_valid) begin
                    next_target_host = dir_high; // RULE4
                    next_state = bpmc_pkg::ST_CDR_RST;
                end
            end
            bpmc_pkg::ST_EQ, bpmc_pkg::ST_DRV: begin
                if (dir_moved) begin
                    next_target_host = dir_high; // RULE10
                    next_state = bpmc_pkg::ST_QUIET; // RULE15
                end
            end
            bpmc_pkg::ST_QUIET: begin
                if (drain_done) begin
                    next_state = bpmc_pkg::ST_CDR_RST; // RULE11
                end
            end
            bpmc_pkg::ST_CDR_RST: begin
                if (cdr_done) begin
                    next_state = target_host ? bpmc_pkg::ST_DRV : bpmc_pkg::ST_EQ; // RULE11
                end
            end
            default: begin
                next_state = bpmc_pkg::ST_STRAP;
            end
        endcase
    end

    // output plan, taken from the next state so every output is a flop
    wire logic ns_eq = (next_state == bpmc_pkg::ST_EQ);
    wire logic ns_drv = (next_state == bpmc_pkg::ST_DRV);
    wire logic ns_rst = (next_state == bpmc_pkg::ST_CDR_RST);
    wire logic ns_strap = (next_state == bpmc_pkg::ST_STRAP);
    wire logic route_loopback = route_valid && !route_high;
    wire logic sec_enabled = sec_valid && !sec_high;
    wire logic next_line_eq = ns_eq || (ns_rst && !next_target_host); // RULE1
    wire logic next_host_eq = ns_drv || (ns_rst && next_target_host); // RULE2
    // coax driver only in driver mode, which never overlaps the equalizer
    wire logic next_line_oe = ns_drv; // RULE3
    wire logic next_host_out = ns_eq || (ns_drv && route_loopback); // RULE5 RULE8
    wire logic next_sec_out = (ns_eq || ns_drv) && sec_enabled; // RULE6 RULE7
    wire logic next_cdr_reset = ns_rst || ns_strap; // RULE11
    wire logic cdr_in = target_host ? host_diff_input : line_coax_port_in;

    // state and timer; the timer restarts on every state change
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state <= bpmc_pkg::ST_STRAP;
            target_host <= 1'b0;
            wait_cnt <= '0;
        end else begin
            state <= next_state;
            target_host <= next_target_host;
            wait_cnt <= (next_state != state) ? '0 : wait_cnt + WAIT_W'(1);
        end
    end

    // path enables and mode flags
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            line_equalizer_enable <= 1'b0;
            host_equalizer_enable <= 1'b0;
            line_coax_port_oe <= 1'b0;
            host_diff_output_enable <= 1'b0;
            secondary_coax_driver_enable <= 1'b0;
            clock_recovery_reset <= 1'b1;
            clock_recovery_source_host <= 1'b0;
            equalizer_mode <= 1'b0;
            driver_mode <= 1'b0;
        end else begin
            line_equalizer_enable <= next_line_eq;
            host_equalizer_enable <= next_host_eq;
            line_coax_port_oe <= next_line_oe;
            host_diff_output_enable <= next_host_out;
            secondary_coax_driver_enable <= next_sec_out;
            clock_recovery_reset <= next_cdr_reset;
            clock_recovery_source_host <= next_target_host;
            equalizer_mode <= ns_eq;
            driver_mode <= ns_drv;
        end
    end

    // reclocker stand-in: one sample of the selected input, quiet while in reset;
    // every driver carries the same reclocked bit, gated by its own enable
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            reclocked <= 1'b0;
            line_coax_port_out <= 1'b0;
            host_diff_output <= 1'b0;
            secondary_coax_driver <= 1'b0;
        end else begin
            reclocked <= clock_recovery_reset ? 1'b0 : cdr_in; // RULE5
            line_coax_port_out <= next_line_oe && reclocked; // RULE2
            host_diff_output <= next_host_out && reclocked; // RULE8
            secondary_coax_driver <= next_sec_out && reclocked; // RULE6 RULE7
        end
    end

    // management ready flag after the power-on ready time
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            por_cnt <= '0;
            mgmt_ready <= 1'b0;
        end else if (por_cnt == POR_W'(POR_READY_CYCLES - 1)) begin
            mgmt_ready <= 1'b1; // RULE14
        end else begin
            por_cnt <= por_cnt + POR_W'(1);
        end
    end

    a_equalizer_mode_paths: assert property (@(posedge clk) disable iff (reset) // RULE1
        equalizer_mode |-> line_equalizer_enable && !line_coax_port_oe && !host_equalizer_enable)
        else $error("equalizer mode without coax input path");
    a_drv_mode_paths: assert property (@(posedge clk) disable iff (reset) // RULE2
        driver_mode |-> line_coax_port_oe && host_equalizer_enable && !line_equalizer_enable)
        else $error("driver mode without coax driver path");
    a_no_both_dirs: assert property (@(posedge clk) disable iff (reset) // RULE3
        !(line_equalizer_enable && line_coax_port_oe))
        else $error("coax equalizer and driver enabled together");
    a_eq_host_out: assert property (@(posedge clk) disable iff (reset) // RULE5
        equalizer_mode |-> host_diff_output_enable && !clock_recovery_source_host
        && !clock_recovery_reset)
        else $error("equalizer mode host output not fed from coax");
    a_loop_through: assert property (@(posedge clk) disable iff (reset) // RULE6
        (in_eq && $past(in_eq) && reclocked && secondary_coax_driver_enable
        && $past(secondary_coax_driver_enable)) |=> secondary_coax_driver == host_diff_output
        || !equalizer_mode)
        else $error("loop-through copy differs from host output");
    a_fanout_data: assert property (@(posedge clk) disable iff (reset) // RULE7
        (driver_mode && secondary_coax_driver_enable) |-> secondary_coax_driver
        == line_coax_port_out)
        else $error("second cable driver differs from main driver");
    a_loopback_data: assert property (@(posedge clk) disable iff (reset) // RULE8
        (driver_mode && host_diff_output_enable) |-> host_diff_output == line_coax_port_out)
        else $error("host loopback differs from cable driver");
    a_relock_change: assert property (@(posedge clk) disable iff (reset) // RULE11
        (in_eq && dir_valid && dir_high) |=> !equalizer_mode ##[1:A_RELOCK_MAX]
        clock_recovery_reset)
        else $error("direction change did not reset clock recovery");
    a_drain_first: assert property (@(posedge clk) disable iff (reset) // RULE15
        $rose(line_coax_port_oe) |-> !$past(host_diff_output_enable)
        && !$past(secondary_coax_driver_enable) && $past(clock_recovery_reset))
        else $error("coax driver enabled before old drivers stopped");
    a_eq_after_reset: assert property (@(posedge clk) disable iff (reset) // RULE10
        $rose(equalizer_mode) |-> $past(clock_recovery_reset) && !clock_recovery_source_host)
        else $error("equalizer mode entered without recovery reset");

    // sequencer checks: the handover states must keep every driver quiet
    a_relock_drv: assert property (@(posedge clk) disable iff (reset) // RULE11
        (in_drv && dir_valid && !dir_high) |=> !driver_mode ##[1:A_RELOCK_MAX]
        clock_recovery_reset)
        else $error("direction change did not reset clock recovery");
    a_quiet_off: assert property (@(posedge clk) disable iff (reset) // RULE15
        (state == bpmc_pkg::ST_QUIET) |-> !line_coax_port_oe
        && !host_diff_output_enable && !secondary_coax_driver_enable)
        else $error("driver left on while draining");
    a_cdr_rst_hold: assert property (@(posedge clk) disable iff (reset) // RULE11
        (state == bpmc_pkg::ST_CDR_RST) |-> clock_recovery_reset)
        else $error("recovery reset low during relock");
    a_cdr_rst_len: assert property (@(posedge clk) disable iff (reset) // RULE11
        $fell(clock_recovery_reset) |-> $past(cdr_done))
        else $error("recovery reset released early");
    a_strap_idle: assert property (@(posedge clk) disable iff (reset) // RULE4
        (state == bpmc_pkg::ST_STRAP) |-> !equalizer_mode && !driver_mode
        && !line_coax_port_oe)
        else $error("mode active before strap settled");
    a_modes_apart: assert property (@(posedge clk) disable iff (reset) // RULE3
        !(equalizer_mode && driver_mode))
        else $error("both modes flagged");
    a_drv_source: assert property (@(posedge clk) disable iff (reset) // RULE2
        driver_mode |-> clock_recovery_source_host && !clock_recovery_reset)
        else $error("driver mode not fed from host input");

    // routing straps: each enable must follow its strap in a steady mode
    a_loopback_on: assert property (@(posedge clk) disable iff (reset) // RULE8
        (in_drv && ns_drv && route_loopback) |=> host_diff_output_enable)
        else $error("host loopback not enabled");
    a_loopback_off: assert property (@(posedge clk) disable iff (reset) // RULE8
        (in_drv && ns_drv && !route_loopback) |=> !host_diff_output_enable)
        else $error("host loopback enabled against strap");
    a_sec_enable: assert property (@(posedge clk) disable iff (reset) // RULE6
        (((in_eq && ns_eq) || (in_drv && ns_drv)) && sec_enabled)
        |=> secondary_coax_driver_enable)
        else $error("secondary driver not enabled");

    // a disabled driver must show a quiet line, not stale data
    a_line_quiet: assert property (@(posedge clk) disable iff (reset) // RULE2
        !line_coax_port_oe |-> !line_coax_port_out)
        else $error("coax data while driver off");
    a_host_quiet: assert property (@(posedge clk) disable iff (reset) // RULE5
        !host_diff_output_enable |-> !host_diff_output)
        else $error("host data while output off");
    a_sec_quiet: assert property (@(posedge clk) disable iff (reset) // RULE6
        !secondary_coax_driver_enable |-> !secondary_coax_driver)
        else $error("secondary data while driver off");
    a_ready_holds: assert property (@(posedge clk) disable iff (reset) // RULE14
        mgmt_ready |=> mgmt_ready)
        else $error("ready flag dropped");

endmodule

`default_nettype wire

// ---- testbench/bpmc_video_link.sv ----
// far-side model: serializer on the coax line and on the host lane
// assumes the bench hands it one bit per clock on each lane
`timescale 1ns/10ps
`default_nettype none

module bpmc_video_link (
    input wire logic coax_drive_bit,
    input wire logic host_drive_bit,
    input wire logic dev_coax_out,
    input wire logic dev_coax_oe,
    output logic coax_wire,
    output logic host_wire
);
    // the far transmitter backs off while the device drives the coax,
    // so the shared line carries exactly one source at a time
    assign coax_wire = dev_coax_oe ? dev_coax_out : coax_drive_bit;
    assign host_wire = host_drive_bit;
endmodule

`default_nettype wire

// ---- testbench/bidir_port_mode_control_tb_top.sv ----
// self-checking bench for the port mode control block
// assumes shortened counts and a behavioural far-side serializer
`timescale 1ns/10ps
`default_nettype none

module bidir_port_mode_control_tb_top;
    localparam int W = bpmc_pkg::CODE_W;
    localparam int DEB = 4;
    localparam int POR = 20;
    typedef struct {int due; logic [12:0] e; logic [12:0] m;} bpmc_note_type;

    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [W-1:0] dir_code, route_code, sec_code;
    logic dir_open, route_open, sec_open, cbit, hbit, coax_in, host_in;
    logic line_out, line_oe, host_out, host_oe, sec, sec_oe, line_eq, host_eq;
    logic cdr_rst, src_host, eq_m, drv_m, ready;
    int cyc = 0;
    int n_fail = 0;
    int compares = 0;
    bpmc_note_type notes[$];
    // strap table: codes sit on both sides of the low/high boundary
    logic [W-1:0] t_dir[6] = '{8'h00, 8'hCC, 8'h33, 8'h80, 8'h7F, 8'h00};
    logic [W-1:0] t_rt[6] = '{8'hFF, 8'hFF, 8'h00, 8'h7F, 8'h00, 8'h33};
    logic [W-1:0] t_sc[6] = '{8'h00, 8'hFF, 8'h7F, 8'h80, 8'h00, 8'h32};
    logic [2:0] t_open[6] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h3, 3'h4};
    logic [2:0] t_exp[6] = '{3'h1, 3'h4, 3'h3, 3'h6, 3'h0, 3'h7};
    wire logic [12:0] obs = {ready, line_out, line_oe, host_out, host_oe, sec, sec_oe,
        line_eq, host_eq, cdr_rst, src_host, eq_m, drv_m};

    always #(bpmc_pkg::CLK_PERIOD_NS / 2) clk = ~clk;

    always @(posedge clk) cyc <= cyc + 1;

    bpmc_port_control #(.DEBOUNCE_CYCLES(DEB), .DRAIN_CYCLES(2), .CDR_RESET_CYCLES(3),
        .POR_READY_CYCLES(POR)) i_bpmc_port_control (
        .clk(clk), .reset(reset),
        .direction_select_code(dir_code), .direction_select_open(dir_open),
        .host_output_route_select_code(route_code), .host_output_route_select_open(route_open),
        .secondary_driver_select_code(sec_code), .secondary_driver_select_open(sec_open),
        .line_coax_port_in(coax_in), .line_coax_port_out(line_out),
        .line_coax_port_oe(line_oe), .host_diff_input(host_in),
        .host_diff_output(host_out), .host_diff_output_enable(host_oe),
        .secondary_coax_driver(sec), .secondary_coax_driver_enable(sec_oe),
        .line_equalizer_enable(line_eq), .host_equalizer_enable(host_eq),
        .clock_recovery_reset(cdr_rst), .clock_recovery_source_host(src_host),
        .equalizer_mode(eq_m), .driver_mode(drv_m), .mgmt_ready(ready)
    );

    bpmc_video_link i_bpmc_video_link (
        .coax_drive_bit(cbit), .host_drive_bit(hbit), .dev_coax_out(line_out),
        .dev_coax_oe(line_oe), .coax_wire(coax_in), .host_wire(host_in)
    );

    task automatic check(input logic [12:0] seen, input logic [12:0] exp,
        input logic [12:0] mask);
        compares++;
        if ((seen & mask) !== (exp & mask)) begin
            n_fail++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // steady-state outputs; the secondary data bit is masked while it is off
    function automatic logic [12:0] exp_vec(input logic drv, input logic rl, input logic sl,
        input logic cb, input logic hb);
        logic d;
        logic ho;
        d = drv ? hb : cb;
        ho = drv ? rl : 1'b1;
        return {1'b1, drv & hb, drv, ho & d, ho, sl & d, sl, !drv, drv, 1'b0, drv, !drv, drv};
    endfunction

    // random bits on both lanes with a short direction glitch that must be ignored
    task automatic run_data(input logic [2:0] x, input int n);
        bpmc_note_type t;
        logic [W-1:0] keep;
        keep = dir_code;
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            #2;
            cbit = 1'($urandom);
            hbit = 1'($urandom);
            if (i == 5) dir_code = ~keep;
            if (i == 7) dir_code = keep;
            t.due = cyc + 2;
            t.e = exp_vec(x[2], x[1], x[0], cbit, hbit);
            t.m = x[0] ? 13'h1FFF : 13'h1F7F;
            notes.push_back(t);
        end
        repeat (3) @(posedge clk);
    endtask

    // change straps, watch the handover, then stream data in the new mode
    task automatic step(input int k);
        logic seen_rst;
        seen_rst = 1'b0;
        @(posedge clk);
        #2;
        {dir_open, route_open, sec_open} = t_open[k];
        dir_code = t_dir[k];
        route_code = t_rt[k];
        sec_code = t_sc[k];
        for (int i = 0; i < 30; i++) begin
            @(posedge clk);
            #1;
            if (cdr_rst === 1'b1) seen_rst = 1'b1;
            check(13'({line_eq & line_oe, eq_m & drv_m}), 13'h0, 13'h3);
            if (eq_m !== 1'b1 && drv_m !== 1'b1) begin
                check(13'({line_oe, host_oe, sec_oe}), 13'h0, 13'h7);
            end
            if ((t_exp[k][2] ? drv_m : eq_m) === 1'b1) break;
        end
        check(13'(seen_rst), 13'h1, 13'h1);
        check(13'({eq_m, drv_m}), 13'({!t_exp[k][2], t_exp[k][2]}), 13'h3);
        repeat (DEB + 8) @(posedge clk);
        run_data(t_exp[k], 24);
    endtask

    task automatic results();
        if (n_fail == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // results appear two edges after the bit is driven; notes carry their due cycle
    always @(posedge clk) begin
        #1;
        while (notes.size() > 0 && notes[0].due <= cyc) begin
            check(obs, notes[0].e, notes[0].m);
            void'(notes.pop_front());
        end
    end

    initial begin
        void'($urandom(68));
        {dir_open, route_open, sec_open} = t_open[0];
        dir_code = t_dir[0];
        route_code = t_rt[0];
        sec_code = t_sc[0];
        cbit = 1'b0;
        hbit = 1'b0;
        repeat (10) @(posedge clk);
        #1;
        check(obs, 13'h0008, 13'h1FFF);
        repeat (10) @(posedge clk);
        #2;
        reset = 1'b0;
        repeat (POR - 1) @(posedge clk);
        #1;
        check(13'(ready), 13'h0, 13'h1);
        repeat (1) @(posedge clk);
        #1;
        check(13'(ready), 13'h1, 13'h1);
        run_data(t_exp[0], 24);
        for (int k = 1; k < 6; k++) begin
            step(k);
        end
        results();
    end

    // a hang is cut short well past the few hundred cycles the run needs
    initial begin
        repeat (4000) @(posedge clk);
        n_fail++;
        results();
    end
endmodule

`default_nettype wire
